// ==== bench/bus_master_model.sv ====
// Purpose: Shared data bus as the bus master sees it
// Assumes: Master drives only with output enable high
// Notes: A floating bus shows the inverse of its last value
module bus_master_model (
  input wire logic mclk,
  input wire logic masterDrive,
  input wire logic [35:0] wrWord,
  input wire logic [31:0] dataOut,
  input wire logic [3:0] parityIoOut,
  input wire logic dataOe_n,
  output logic [31:0] busData,
  output logic [3:0] busPar,
  output logic clash
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] lastQ = 36'h0;
  assign {busPar, busData} = masterDrive ? wrWord : !dataOe_n ? {parityIoOut, dataOut} : ~lastQ;
  assign clash = masterDrive && !dataOe_n;
  always @(posedge mclk)
    lastQ <= {busPar, busData};
endmodule : bus_master_model

// ==== bench/sync_burst_sram_access_properties.sv ====
// Purpose: Port checks for the burst SRAM access block
// Assumes: Pins act two edges after sampling
// Notes: Outputs are seen one edge later again
`include "sync_burst_sram_regs.svh"
module sync_burst_sram_access_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic primaryChipSel_n,
  input wire logic expandChipSel,
  input wire logic expandChipSel_n,
  input wire logic procAddrStrobe_n,
  input wire logic ctrlAddrStrobe_n,
  input wire logic burstStep_n,
  input wire logic byteWriteGate_n,
  input wire logic [`SBS_LANES-1:0] byteLaneSelect_n,
  input wire logic globalWrite_n,
  input wire logic outputEnable_n,
  input wire logic [`SBS_LANES*`SBS_BYTE_W-1:0] dataOut,
  input wire logic [`SBS_LANES-1:0] parityIoOut,
  input wire logic dataOe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic sel;
  logic noWr;
  assign sel = !primaryChipSel_n && expandChipSel && !expandChipSel_n;
  assign noWr = globalWrite_n && byteWriteGate_n;
  a_ctrl_read_drive: assert property (
    sel && !ctrlAddrStrobe_n && procAddrStrobe_n && noWr && !outputEnable_n |-> ##3 !dataOe_n)
    else $error("ctrl strobe read not driven");
  a_proc_read_drive: assert property (
    sel && !procAddrStrobe_n && !outputEnable_n |-> ##3 !dataOe_n)
    else $error("proc strobe read not driven");
  a_proc_ignored: assert property (
    primaryChipSel_n && !procAddrStrobe_n && !ctrlAddrStrobe_n |-> ##3 dataOe_n)
    else $error("proc strobe taken while deselected");
  a_expand_deselect: assert property (
    !ctrlAddrStrobe_n && !(expandChipSel && !expandChipSel_n) |-> ##3 dataOe_n)
    else $error("drive while expansion deselected");
  a_write_floats: assert property (
    (!globalWrite_n || (!byteWriteGate_n && byteLaneSelect_n != 4'hf)) && procAddrStrobe_n
    |-> ##3 dataOe_n)
    else $error("drive during write");
  a_oe_gates: assert property (
    outputEnable_n |-> ##3 dataOe_n)
    else $error("drive with output enable high");
  a_burst_step: assert property (
    sel && !ctrlAddrStrobe_n && procAddrStrobe_n && noWr ##1 !burstStep_n && noWr
    && procAddrStrobe_n && ctrlAddrStrobe_n && !outputEnable_n |-> ##3 !dataOe_n)
    else $error("burst beat not driven");
  a_data_holds: assert property (
    $changed({parityIoOut, dataOut}) && !$past(outputEnable_n, 3) |-> !dataOe_n)
    else $error("read data changed without drive");
endmodule : sync_burst_sram_access_checker
bind sync_burst_sram_access sync_burst_sram_access_checker chk_u (.mclk, .arst_n,
  .primaryChipSel_n, .expandChipSel, .expandChipSel_n, .procAddrStrobe_n, .ctrlAddrStrobe_n,
  .burstStep_n, .byteWriteGate_n, .byteLaneSelect_n, .globalWrite_n, .outputEnable_n,
  .dataOut, .parityIoOut, .dataOe_n);

// ==== bench/sync_burst_sram_access_test.sv ====
// Purpose: Self-checking bench for the burst SRAM access block
// Assumes: ADDR_W of 6, so the whole array is filled first
// Notes: Reads are checked in order by a monitor on dataOe_n
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module sync_burst_sram_access_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] addrIn = 6'h0;
  logic primaryChipSel_n = 1'b0;
  logic expandChipSel = 1'b1;
  logic expandChipSel_n = 1'b0;
  logic procAddrStrobe_n = 1'b1;
  logic ctrlAddrStrobe_n = 1'b1;
  logic burstStep_n = 1'b1;
  logic byteWriteGate_n = 1'b1;
  logic [3:0] byteLaneSelect_n = 4'hf;
  logic globalWrite_n = 1'b1;
  logic outputEnable_n = 1'b1;
  logic burstOrder = 1'b1;
  logic masterDrive = 1'b0;
  logic [35:0] wrWord = 36'h0;
  logic [31:0] dataIn, dataOut;
  logic [3:0] parityIoIn, parityIoOut;
  logic dataOe_n, writeBusy, clash;
  logic [35:0] mem [64];
  logic [35:0] expQ [$];
  logic [35:0] expW;
  logic [31:0] seed = 32'h20c35270;
  int mismatches = 0;
  int checkCount = 0;
  int turn = 0;
  always #5 mclk = ~mclk;
  sync_burst_sram_access #(.ADDR_W(6)) dut_u (.mclk, .arst_n, .addrIn, .primaryChipSel_n,
    .expandChipSel, .expandChipSel_n, .procAddrStrobe_n, .ctrlAddrStrobe_n, .burstStep_n,
    .byteWriteGate_n, .byteLaneSelect_n, .globalWrite_n, .outputEnable_n, .burstOrder,
    .dataIn, .parityIoIn, .dataOut, .parityIoOut, .dataOe_n, .writeBusy);
  bus_master_model bus_u (.mclk, .masterDrive, .wrWord, .dataOut, .parityIoOut, .dataOe_n,
    .busData(dataIn), .busPar(parityIoIn), .clash);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic complete_run();
    if (mismatches == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Pin vector: strobes, step, writes, oe, selects, drive
  // ----------------------------------------
  task automatic cyc(input logic [9:0] v);
    {procAddrStrobe_n, ctrlAddrStrobe_n, burstStep_n, globalWrite_n, byteWriteGate_n,
      outputEnable_n, primaryChipSel_n, expandChipSel, expandChipSel_n, masterDrive} = v;
    @(posedge mclk);
    #1;
  endtask : cyc
  task automatic desel();
    cyc(10'h0f0 | {6'h0, turn % 3 == 0 ? 3'h6 : turn % 3 == 1 ? 3'h0 : 3'h3, 1'h0});
    turn++;
  endtask : desel
  task automatic wr(input logic [5:0] a, input logic [35:0] w, input logic gw,
    input logic byte_write_gate_n, input logic [3:0] ln);
    logic [3:0] m;
    m = !gw ? 4'hf : !byte_write_gate_n ? ~ln : 4'h0;
    for (int l = 0; l < 4; l++)
      if (m[l])
      begin
        mem[a][l*8+:8] = w[l*8+:8];
        mem[a][32+l] = w[32+l];
      end
    addrIn = a;
    cyc(10'h1f4);
    wrWord = w;
    byteLaneSelect_n = ln;
    cyc(10'h395 | {3'h0, gw, byte_write_gate_n, 5'h0});
    byteLaneSelect_n = 4'hf;
    desel();
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic ord, input logic pr, input int n);
    logic [1:0] lo;
    addrIn = a;
    burstOrder = ord;
    for (int b = 0; b < n; b++)
    begin
      lo = ord ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b);
      expQ.push_back(mem[{a[5:2], lo}]);
      cyc(b > 0 ? 10'h364 : pr ? 10'h0a4 : 10'h2e4);
    end
    desel();
  endtask : rd
  always @(posedge mclk)
  begin
    #2;
    `CHK(clash, 1'b0)
    `CHK(writeBusy, 1'b0)
    if (dataOe_n === 1'b0)
    begin
      expW = expQ.size() > 0 ? expQ.pop_front() : 36'hx;
      `CHK({parityIoOut, dataOut}, expW)
    end
  end
  initial
  begin
    #50us;
    mismatches++;
    complete_run();
  end
  initial
  begin
    logic [31:0] r;
    repeat (16) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    for (int a = 0; a < 64; a++)
    begin
      r = xs();
      wr(6'(a), {r[3:0], xs()}, 1'b0, 1'b1, r[7:4]);
    end
    repeat (24)
    begin
      r = xs();
      wr(r[5:0], {r[31:28], xs()}, r[6], r[7], r[11:8]);
    end
    r = xs();
    addrIn = 6'h24;
    cyc(10'h1f4);
    wrWord = {r[3:0], r};
    repeat (12) cyc(10'h335);
    desel();
    for (int i = 0; i < 4; i++)
      mem[6'h24 + i] = {r[3:0], r};
    cyc(10'h1ec);
    repeat (40) cyc(10'h3f4);
    for (int i = 0; i < 16; i++)
    begin
      r = xs();
      rd({r[5:2], 2'(i)}, i[2], i[3], i > 11 ? 1 : 4);
    end
    repeat (8) cyc(10'h3f4);
    `CHK(expQ.size(), 0)
    complete_run();
  end
endmodule : sync_burst_sram_access_test

// ==== src/burst_fifo.sv ====
// Purpose: Write buffer between bus capture and the storage array
// Assumes: Depth is a power of two
// Notes: Input ready drops when full; output valid drops when empty
module burst_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != DEPTH[PW:0]);
  assign outValid = (count_q != '0);
  assign outData = store[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      store[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : burst_fifo

// ==== src/sync_burst_sram_access.sv ====
// Purpose: Access control and storage of a flow-through burst SRAM
// Assumes: Pins are asynchronous to mclk and pass two flip-flops
// Notes: Writes drain from a buffer; reads take the array first
`include "sync_burst_sram_regs.svh"

module sync_burst_sram_access #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic primaryChipSel_n,
  input wire logic expandChipSel,
  input wire logic expandChipSel_n,
  input wire logic procAddrStrobe_n,
  input wire logic ctrlAddrStrobe_n,
  input wire logic burstStep_n,
  input wire logic byteWriteGate_n,
  input wire logic [`SBS_LANES-1:0] byteLaneSelect_n,
  input wire logic globalWrite_n,
  input wire logic outputEnable_n,
  input wire logic burstOrder,
  input wire logic [`SBS_LANES*`SBS_BYTE_W-1:0] dataIn,
  input wire logic [`SBS_LANES-1:0] parityIoIn,
  output logic [`SBS_LANES*`SBS_BYTE_W-1:0] dataOut,
  output logic [`SBS_LANES-1:0] parityIoOut,
  output logic dataOe_n,
  output logic writeBusy
);

  localparam int FW = ADDR_W + `SBS_LANES + `SBS_WORD_W;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] burstLow(input logic [1:0] first,
                                          input logic [1:0] beat,
                                          input logic interleaved);
    if (interleaved)
    begin
      burstLow = first ^ beat;
    end
    else
    begin
      burstLow = first + beat;
    end
  endfunction : burstLow

  function automatic logic [`SBS_WORD_W-1:0] packWord(
    input logic [`SBS_LANES*`SBS_BYTE_W-1:0] d,
    input logic [`SBS_LANES-1:0] p);
    logic [`SBS_WORD_W-1:0] w;
    w = '0;
    for (int l = 0; l < `SBS_LANES; l++)
    begin
      w[l*`SBS_LANE_W +: `SBS_LANE_W] = {p[l], d[l*`SBS_BYTE_W +: `SBS_BYTE_W]};
    end
    packWord = w;
  endfunction : packWord

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  logic [`SBS_P_W-1:0] pinS1_q;
  logic [`SBS_P_W-1:0] pinS2_q;
  logic [`SBS_LANES-1:0] laneS1_q;
  logic [`SBS_LANES-1:0] laneS2_q;
  logic [ADDR_W-1:0] addrS1_q;
  logic [ADDR_W-1:0] addrS2_q;
  logic [`SBS_WORD_W-1:0] wordS1_q;
  logic [`SBS_WORD_W-1:0] wordS2_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinS1_q <= `SBS_PIN_IDLE;
      pinS2_q <= `SBS_PIN_IDLE;
      laneS1_q <= `SBS_LANES_ALL;
      laneS2_q <= `SBS_LANES_ALL;
      addrS1_q <= '0;
      addrS2_q <= '0;
      wordS1_q <= '0;
      wordS2_q <= '0;
    end
    else
    begin
      pinS1_q <= {burstOrder, outputEnable_n, globalWrite_n, byteWriteGate_n,
                  burstStep_n, ctrlAddrStrobe_n, procAddrStrobe_n,
                  expandChipSel_n, expandChipSel, primaryChipSel_n};
      pinS2_q <= pinS1_q;
      laneS1_q <= byteLaneSelect_n;
      laneS2_q <= laneS1_q;
      addrS1_q <= addrIn;
      addrS2_q <= addrS1_q;
      wordS1_q <= packWord(dataIn, parityIoIn);
      wordS2_q <= wordS1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic chipsOk;
  logic procStrobe;
  logic ctrlStrobe;
  logic stepReq;
  logic outEnable;
  logic [`SBS_LANES-1:0] laneMask;
  logic writeInd;

  assign chipsOk = !pinS2_q[`SBS_P_CE1N] && pinS2_q[`SBS_P_CE2] && !pinS2_q[`SBS_P_CE3N];
  assign procStrobe = !pinS2_q[`SBS_P_PROC_ADDR_STROBE_N] && !pinS2_q[`SBS_P_CE1N];
  assign ctrlStrobe = !pinS2_q[`SBS_P_CTRL_ADDR_STROBE_N];
  assign stepReq = !pinS2_q[`SBS_P_ADV];
  assign outEnable = !pinS2_q[`SBS_P_OE];

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  // byte gate and lanes
  always_comb
  begin
    if (!pinS2_q[`SBS_P_GW])
    begin
      laneMask = `SBS_LANES_ALL;
    end
    else if (!pinS2_q[`SBS_P_BWE])
    begin
      laneMask = ~laneS2_q;
    end
    else
    begin
      laneMask = `SBS_LANES_NONE;
    end
  end
  assign writeInd = (laneMask != `SBS_LANES_NONE);

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  sync_burst_sram_pkg::access_state_e state_q;
  sync_burst_sram_pkg::access_state_e state_d;
  logic [ADDR_W-1:0] addrBase_q;
  logic [ADDR_W-1:0] addrBase_d;
  logic [1:0] firstLow_q;
  logic [1:0] firstLow_d;
  sync_burst_sram_pkg::beat_t beat_q;
  sync_burst_sram_pkg::beat_t beat_d;
  logic order_q;
  logic order_d;
  logic readNow;
  logic writeNow;
  logic [ADDR_W-1:0] curAddr;

  always_comb
  begin
    state_d = state_q;
    addrBase_d = addrBase_q;
    firstLow_d = firstLow_q;
    beat_d = beat_q;
    order_d = order_q;
    readNow = 1'b0;
    writeNow = 1'b0;
    if (procStrobe)
    begin
      state_d = chipsOk ? sync_burst_sram_pkg::ST_BURST : sync_burst_sram_pkg::ST_IDLE;
      readNow = chipsOk;
    end
    else if (ctrlStrobe)
    begin
      state_d = chipsOk ? sync_burst_sram_pkg::ST_BURST : sync_burst_sram_pkg::ST_IDLE;
      writeNow = chipsOk && writeInd;
      readNow = chipsOk && !writeInd;
    end
    else if (state_q == sync_burst_sram_pkg::ST_BURST)
    begin
      if (stepReq)
      begin
        beat_d = beat_q + 2'h1;
      end
      writeNow = writeInd;
      readNow = !writeInd;
    end
    if ((procStrobe || ctrlStrobe) && chipsOk)
    begin
      addrBase_d = addrS2_q;
      firstLow_d = addrS2_q[1:0];
      beat_d = 2'h0;
      order_d = pinS2_q[`SBS_P_MODE];
    end
  end

  // ----------------------------------------------------------------
  // Burst address
  // ----------------------------------------------------------------
  // two-bit wrap
  assign curAddr = {addrBase_d[ADDR_W-1:2], burstLow(firstLow_d, beat_d, order_d)};

  // ----------------------------------------------------------------
  // Sequencing registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= sync_burst_sram_pkg::ST_IDLE;
      addrBase_q <= '0;
      firstLow_q <= 2'h0;
      beat_q <= 2'h0;
      order_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      addrBase_q <= addrBase_d;
      firstLow_q <= firstLow_d;
      beat_q <= beat_d;
      order_q <= order_d;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and array
  // ----------------------------------------------------------------
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [FW-1:0] fifoOutData;
  logic [ADDR_W-1:0] drainAddr;
  logic [`SBS_LANES-1:0] drainMask;
  logic [`SBS_WORD_W-1:0] drainWord;
  logic drainNow;

  // Reads own the array port, so draining waits
  assign fifoOutReady = !readNow;
  assign drainNow = fifoOutValid && fifoOutReady;
  assign {drainAddr, drainMask, drainWord} = fifoOutData;

  burst_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .inValid(writeNow),
    .inReady(fifoInReady),
    .inData({curAddr, laneMask, wordS2_q}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ----------------------------------------------------------------
  // Storage array, one bank per byte lane
  // ----------------------------------------------------------------
  logic [`SBS_LANES*`SBS_BYTE_W-1:0] readData;
  logic [`SBS_LANES-1:0] readPar;

  for (genvar l = 0; l < `SBS_LANES; l++)
  begin : g_lane
    logic [`SBS_LANE_W-1:0] laneMem [2**ADDR_W];
    logic [`SBS_LANE_W-1:0] laneWord;

    always_ff @(posedge mclk)
    begin
      if (drainNow && drainMask[l])
      begin
        laneMem[drainAddr] <= drainWord[l*`SBS_LANE_W +: `SBS_LANE_W];
      end
    end

    // Lane word is parity above eight data bits
    assign laneWord = laneMem[curAddr];
    assign readData[l*`SBS_BYTE_W +: `SBS_BYTE_W] = laneWord[`SBS_BYTE_W-1:0];
    assign readPar[l] = laneWord[`SBS_BYTE_W];
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  // flow-through read
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataOut <= '0;
      parityIoOut <= '0;
    end
    else if (readNow)
    begin
      dataOut <= readData;
      parityIoOut <= readPar;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataOe_n <= 1'b1;
    end
    else
    begin
      dataOe_n <= !(readNow && outEnable && !writeNow);
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  // Back-pressure seen by the master
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      writeBusy <= 1'b0;
    end
    else
    begin
      writeBusy <= !fifoInReady;
    end
  end

endmodule : sync_burst_sram_access

// ==== src/sync_burst_sram_pkg.sv ====
// Purpose: Types for the synchronous burst SRAM access block
// Assumes: Nothing beyond the constants header
// Notes: States use explicit binary codes
package sync_burst_sram_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BURST = 1'b1
  } access_state_e;

  typedef logic [1:0] beat_t;

endpackage : sync_burst_sram_pkg

// ==== src/sync_burst_sram_regs.svh ====
// Purpose: Constants for the synchronous burst SRAM access block
// Assumes: One clock, mclk at 100 MHz
// Notes: Functional notes below, one line each
`ifndef SYNC_BURST_SRAM_REGS_SVH
`define SYNC_BURST_SRAM_REGS_SVH

`define SBS_LANES 4
`define SBS_BYTE_W 8
`define SBS_LANE_W 9
`define SBS_WORD_W 36
`define SBS_ADDR_W 20
`define SBS_FIFO_DEPTH 32
`define SBS_LANES_ALL 4'hf
`define SBS_LANES_NONE 4'h0
`define SBS_BEAT_W 2

// Control pin bundle positions
`define SBS_P_CE1N 0
`define SBS_P_CE2 1
`define SBS_P_CE3N 2
`define SBS_P_PROC_ADDR_STROBE_N 3
`define SBS_P_CTRL_ADDR_STROBE_N 4
`define SBS_P_ADV 5
`define SBS_P_BWE 6
`define SBS_P_GW 7
`define SBS_P_OE 8
`define SBS_P_MODE 9
`define SBS_P_W 10
// Idle pin values: low-active pins high, expansion select low, order high
`define SBS_PIN_IDLE 10'h3fd

// Timing, clock period and data valid after clock edge
`define SBS_CLK_PERIOD_PS 10000
`define SBS_CLOCK_TO_DATA_VALID_PS 6500
`define SBS_CLOCK_TO_DATA_VALID_CYC \
  (((`SBS_CLOCK_TO_DATA_VALID_PS) / (`SBS_CLK_PERIOD_PS)) > 0 ? \
  ((`SBS_CLOCK_TO_DATA_VALID_PS) / (`SBS_CLK_PERIOD_PS)) : 1)

`endif
